// ### rtl/gpt_defines.svh
// Constants for the graphics port target and fast-write ends.
// Assumes inclusion by bare name from rtl/.
`ifndef GPT_DEFINES_SVH
`define GPT_DEFINES_SVH
// Pipelined and sideband command codes
`define GPT_CMD_RD 4'h0
`define GPT_CMD_RD_HI 4'h1
`define GPT_CMD_WR 4'h4
`define GPT_CMD_WR_HI 4'h5
`define GPT_CMD_LRD 4'h8
`define GPT_CMD_LRD_HI 4'h9
`define GPT_CMD_FLUSH 4'hA
`define GPT_CMD_FENCE 4'hC
// Frame-protocol memory command codes
`define GPT_FCMD_MRD 4'h6
`define GPT_FCMD_MWR 4'h7
`define GPT_FCMD_MRM 4'hC
`define GPT_FCMD_MRL 4'hE
`define GPT_FCMD_MWI 4'hF
// Address map, fill data and byte enables
`define GPT_HUB_BASE 32'h4000_0000
`define GPT_FILL_QW 64'hA5A5_A5A5_A5A5_A5A5
`define GPT_BE_ALL 8'hFF
`define GPT_BE_NONE 8'h00
// Port command register fields and status capability
`define GPT_FAST_WRITE_ENABLE_BIT_BIT 4
`define GPT_RATE_1X_BIT 0
`define GPT_RATE_2X_BIT 1
`define GPT_RATE_4X_BIT 2
`define GPT_RATE_CAP 3'h7
`define GPT_RATE_NONE 3'h0
// Block timing, byte counts per link clock and outstanding-write counter limits
`define GPT_BLOCK_LAST 2'h3
`define GPT_BYTES_1X 16'h0004
`define GPT_BYTES_2X 16'h0008
`define GPT_BYTES_4X 16'h0010
`define GPT_WR_MAX 4'hF
`define GPT_WR_ONE 4'h1
`define GPT_WR_ZERO 4'h0
`endif

// ### rtl/gpt_pkg.sv
// Types shared by the link interface and both ends.
// Assumes nothing beyond a SystemVerilog compiler.
package gpt_pkg;
    typedef enum logic [1:0] {
        GPT_R1X = 2'b00,
        GPT_R2X = 2'b01,
        GPT_R4X = 2'b10
    } gpt_rate_t;

    typedef enum logic [1:0] {
        GPT_FW_IDLE = 2'b00,
        GPT_FW_BLK = 2'b01,
        GPT_FW_GAP = 2'b10
    } gpt_fw_st_t;

    typedef struct packed {
        logic ce_s1;
        logic ce_s2;
        logic [7:0] cmd_s1;
        logic [7:0] cmd_s2;
        logic fwt_s1;
        logic fwt_s2;
        logic fwt_seen;
        logic ack_tgl;
        logic rate_lock;
        logic fw_en;
        gpt_rate_t mode;
        logic [2:0] rate_cap;
        gpt_fw_st_t fst;
        logic [1:0] fcnt;
        logic fw_valid;
        logic [31:0] fw_data;
        gpt_rate_t fw_rate;
        logic [1:0] ad_stb;
        logic [1:0] ad_stb_n;
        logic sb_stb_n;
        logic req_ready;
        logic rsp_valid;
        logic [63:0] rsp_data;
        logic mem_valid;
        logic mem_write;
        logic mem_hi;
        logic mem_snoop;
        logic [7:0] mem_be;
        logic [31:0] mem_addr;
        logic [63:0] mem_wdata;
        logic rd_busy;
        logic [3:0] wr_out;
        logic fence;
    } gpt_dev_lk_t;

    typedef struct packed {
        logic fw_tgl;
        logic ack_s1;
        logic ack_s2;
        logic busy;
        logic [31:0] data;
    } gpt_dev_core_t;

    typedef struct packed {
        logic ce_s1;
        logic ce_s2;
        logic rq_s1;
        logic rq_s2;
        logic rq_seen;
        logic req_valid;
        logic ack_tgl;
        logic rsp_tgl;
        logic [63:0] rsp_data;
        logic [15:0] fw_bytes;
    } gpt_gfx_lk_t;

    typedef struct packed {
        logic rq_tgl;
        logic ack_s1;
        logic ack_s2;
        logic busy;
        logic rs_s1;
        logic rs_s2;
        logic rs_seen;
        logic [3:0] cmd;
        logic [31:0] addr;
        logic [63:0] wdata;
        logic frame;
        logic rsp_valid;
        logic [63:0] rsp_data;
    } gpt_gfx_core_t;
endpackage

// ### rtl/gpt_link_if.sv
// Port link between the hub end and the graphics controller end.
// Assumes the bench supplies the link clock.
`timescale 1ns/10ps
interface gpt_link_if (
    input wire logic link_clk
);
    logic req_valid;
    logic req_ready;
    logic [3:0] req_cmd;
    logic [31:0] req_addr;
    logic [63:0] req_wdata;
    logic req_frame;
    logic rsp_valid;
    logic [63:0] rsp_data;
    logic fw_valid;
    logic [31:0] fw_data;
    gpt_pkg::gpt_rate_t fw_rate;
    logic [1:0] ad_stb;
    logic [1:0] ad_stb_n;
    logic sb_stb_n;

    modport dev (
        input link_clk, req_valid, req_cmd, req_addr, req_wdata, req_frame,
        output req_ready, rsp_valid, rsp_data, fw_valid, fw_data, fw_rate,
        output ad_stb, ad_stb_n, sb_stb_n
    );
    modport gfx (
        input link_clk, req_ready, rsp_valid, rsp_data, fw_valid, fw_data, fw_rate,
        input ad_stb, ad_stb_n, sb_stb_n,
        output req_valid, req_cmd, req_addr, req_wdata, req_frame
    );
endinterface

// ### rtl/gpt_gfx_end.sv
// Graphics controller end: issues port requests, collects answers
// and fast-write blocks. Assumes user side on core_clk_in.
`timescale 1ns/10ps
`include "gpt_defines.svh"
module gpt_gfx_end (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic clk_en_in,
    gpt_link_if.gfx lk,
    input wire logic cmd_valid_in,
    input wire logic [3:0] cmd_in,
    input wire logic [31:0] addr_in,
    input wire logic [63:0] wdata_in,
    input wire logic frame_in,
    output logic cmd_busy_out,
    output logic rsp_valid_out,
    output logic [63:0] rsp_data_out,
    output logic [15:0] fw_bytes_out
);
    import gpt_pkg::*;

    gpt_gfx_lk_t s_reg, s_next;
    gpt_gfx_core_t c_reg, c_next;

    // ----------------------------------------
    // Link side
    // ----------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.ce_s1 = clk_en_in;
        s_next.ce_s2 = s_reg.ce_s1;
        s_next.rq_s1 = c_reg.rq_tgl;
        s_next.rq_s2 = s_reg.rq_s1;
        if (s_reg.ce_s2) begin
            if (s_reg.req_valid && lk.req_ready) begin
                s_next.req_valid = 1'b0;
                s_next.ack_tgl = ~s_reg.ack_tgl;
            end else if (!s_reg.req_valid && (s_reg.rq_s2 != s_reg.rq_seen)) begin
                s_next.rq_seen = s_reg.rq_s2;
                s_next.req_valid = 1'b1;
            end
            if (lk.rsp_valid) begin
                s_next.rsp_data = lk.rsp_data;
                s_next.rsp_tgl = ~s_reg.rsp_tgl;
            end
            // Bytes per link clock follow the rate carried with the block
            if (lk.fw_valid) begin
                case (lk.fw_rate)
                    GPT_R4X: s_next.fw_bytes = s_reg.fw_bytes + `GPT_BYTES_4X;
                    GPT_R2X: s_next.fw_bytes = s_reg.fw_bytes + `GPT_BYTES_2X;
                    default: s_next.fw_bytes = s_reg.fw_bytes + `GPT_BYTES_1X;
                endcase
            end
        end
    end

    always_ff @(posedge lk.link_clk or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Held stable by the toggle handshake while a request is open
    assign lk.req_valid = s_reg.req_valid;
    assign lk.req_cmd = c_reg.cmd;
    assign lk.req_addr = c_reg.addr;
    assign lk.req_wdata = c_reg.wdata;
    assign lk.req_frame = c_reg.frame;
    assign fw_bytes_out = s_reg.fw_bytes;

    // ----------------------------------------
    // User side
    // ----------------------------------------
    always_comb begin
        c_next = c_reg;
        c_next.ack_s1 = s_reg.ack_tgl;
        c_next.ack_s2 = c_reg.ack_s1;
        c_next.rs_s1 = s_reg.rsp_tgl;
        c_next.rs_s2 = c_reg.rs_s1;
        c_next.rsp_valid = 1'b0;
        if (cmd_valid_in && !c_reg.busy) begin
            c_next.cmd = cmd_in;
            c_next.addr = addr_in;
            c_next.wdata = wdata_in;
            c_next.frame = frame_in;
            c_next.rq_tgl = ~c_reg.rq_tgl;
        end
        c_next.busy = c_next.rq_tgl != c_reg.ack_s2;
        if (c_reg.rs_s2 != c_reg.rs_seen) begin
            c_next.rs_seen = c_reg.rs_s2;
            c_next.rsp_valid = 1'b1;
            c_next.rsp_data = s_reg.rsp_data;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            c_reg <= '0;
        end else if (clk_en_in) begin
            c_reg <= c_next;
        end
    end

    assign cmd_busy_out = c_reg.busy;
    assign rsp_valid_out = c_reg.rsp_valid;
    assign rsp_data_out = c_reg.rsp_data;
endmodule

// ### rtl/gpt_dev_end.sv
// Hub end of the graphics port: target decode toward main memory and
// fast-write initiator toward the graphics controller.
// Assumes memory port is synchronous to the link clock; port command
// register bits and fast-write requests come from the core clock.
`timescale 1ns/10ps
`include "gpt_defines.svh"
module gpt_dev_end (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic clk_en_in,
    gpt_link_if.dev lk,
    input wire logic [7:0] port_command_register_in,
    output logic [2:0] rate_cap_out,
    output gpt_pkg::gpt_rate_t rate_mode_out,
    output logic rate_locked_out,
    input wire logic fw_req_in,
    input wire logic [31:0] fw_data_in,
    output logic fw_busy_out,
    output logic mem_valid_out,
    output logic mem_write_out,
    output logic mem_hi_pri_out,
    output logic mem_snoop_out,
    output logic [7:0] mem_be_out,
    output logic [31:0] mem_addr_out,
    output logic [63:0] mem_wdata_out,
    input wire logic mem_ready_in,
    input wire logic mem_rvalid_in,
    input wire logic [63:0] mem_rdata_in,
    input wire logic mem_wack_in,
    output logic fence_active_out
);
    import gpt_pkg::*;

    gpt_dev_lk_t s_reg, s_next;
    gpt_dev_core_t c_reg, c_next;

    // ----------------------------------------
    // Link side
    // ----------------------------------------
    always_comb begin
        logic take;
        logic hub;
        logic wr_inc;
        logic start;
        logic pend;
        gpt_rate_t fw_mode;
        take = 1'b0;
        hub = 1'b0;
        wr_inc = 1'b0;
        start = 1'b0;
        pend = 1'b0;
        fw_mode = GPT_R1X;
        s_next = s_reg;
        // Synchronisers run even while frozen so re-enable is seen
        s_next.ce_s1 = clk_en_in;
        s_next.ce_s2 = s_reg.ce_s1;
        s_next.cmd_s1 = port_command_register_in;
        s_next.cmd_s2 = s_reg.cmd_s1;
        s_next.fwt_s1 = c_reg.fw_tgl;
        s_next.fwt_s2 = s_reg.fwt_s1;
        if (s_reg.ce_s2) begin
            s_next.rate_cap = `GPT_RATE_CAP;
            s_next.rsp_valid = 1'b0;
            // Rate is captured once; later changes are ignored
            if (!s_reg.rate_lock && (s_reg.cmd_s2[2:0] != `GPT_RATE_NONE)) begin
                s_next.rate_lock = 1'b1;
                s_next.fw_en = s_reg.cmd_s2[`GPT_FAST_WRITE_ENABLE_BIT_BIT];
                // Lowest set bit wins if software sets more than one
                if (s_reg.cmd_s2[`GPT_RATE_1X_BIT]) begin
                    s_next.mode = GPT_R1X;
                end else if (s_reg.cmd_s2[`GPT_RATE_2X_BIT]) begin
                    s_next.mode = GPT_R2X;
                end else begin
                    s_next.mode = GPT_R4X;
                end
            end
            // ----------------------------------------
            // Memory port
            // ----------------------------------------
            if (s_reg.mem_valid && mem_ready_in) begin
                s_next.mem_valid = 1'b0;
                wr_inc = s_reg.mem_write;
            end
            if (mem_rvalid_in && s_reg.rd_busy) begin
                s_next.rd_busy = 1'b0;
                s_next.rsp_valid = 1'b1;
                s_next.rsp_data = mem_rdata_in;
            end
            s_next.wr_out = s_reg.wr_out + (wr_inc ? `GPT_WR_ONE : `GPT_WR_ZERO)
                - (mem_wack_in ? `GPT_WR_ONE : `GPT_WR_ZERO);
            if (s_reg.fence && (s_reg.wr_out == `GPT_WR_ZERO) && !s_reg.mem_valid) begin
                s_next.fence = 1'b0;
            end
            // ----------------------------------------
            // Request decode
            // ----------------------------------------
            take = lk.req_valid && s_reg.req_ready;
            hub = lk.req_addr >= `GPT_HUB_BASE;
            if (take) begin
                s_next.mem_addr = lk.req_addr;
                s_next.mem_wdata = lk.req_wdata;
                s_next.mem_hi = 1'b0;
                s_next.mem_be = `GPT_BE_ALL;
                s_next.mem_snoop = lk.req_frame;
                if (lk.req_frame) begin
                    // Hub-bound frame accesses are not claimed
                    if (!hub) begin
                        case (lk.req_cmd)
                            `GPT_FCMD_MRD, `GPT_FCMD_MRM, `GPT_FCMD_MRL: begin
                                s_next.mem_valid = 1'b1;
                                s_next.mem_write = 1'b0;
                                s_next.rd_busy = 1'b1;
                            end
                            `GPT_FCMD_MWR, `GPT_FCMD_MWI: begin
                                s_next.mem_valid = 1'b1;
                                s_next.mem_write = 1'b1;
                            end
                            default: begin
                                s_next.mem_valid = s_reg.mem_valid;
                            end
                        endcase
                    end
                end else begin
                    case (lk.req_cmd)
                        `GPT_CMD_RD, `GPT_CMD_RD_HI, `GPT_CMD_LRD, `GPT_CMD_LRD_HI: begin
                            if (hub) begin
                                s_next.rsp_valid = 1'b1;
                                s_next.rsp_data = `GPT_FILL_QW;
                            end else begin
                                s_next.mem_valid = 1'b1;
                                s_next.mem_write = 1'b0;
                                s_next.mem_hi = lk.req_cmd[0];
                                s_next.rd_busy = 1'b1;
                            end
                        end
                        `GPT_CMD_WR, `GPT_CMD_WR_HI: begin
                            s_next.mem_valid = 1'b1;
                            s_next.mem_write = 1'b1;
                            s_next.mem_hi = lk.req_cmd[0];
                            s_next.mem_be = hub ? `GPT_BE_NONE : `GPT_BE_ALL;
                        end
                        `GPT_CMD_FLUSH: begin
                            s_next.rsp_valid = 1'b1;
                            s_next.rsp_data = `GPT_FILL_QW;
                        end
                        `GPT_CMD_FENCE: begin
                            // Marker only matters while writes are still open
                            s_next.fence = (s_next.wr_out != `GPT_WR_ZERO) || wr_inc;
                        end
                        default: begin
                            s_next.fence = s_next.fence;
                        end
                    endcase
                end
            end
            // Whole port stalls behind a fence: simpler than per-read holds
            s_next.req_ready = !s_next.mem_valid && !s_next.rd_busy && !s_next.fence
                && (s_next.wr_out != `GPT_WR_MAX);
            // ----------------------------------------
            // Fast-write initiator
            // ----------------------------------------
            pend = s_reg.fwt_s2 != s_reg.fwt_seen;
            fw_mode = (s_reg.rate_lock && s_reg.fw_en) ? s_reg.mode : GPT_R1X;
            case (s_reg.fst)
                GPT_FW_IDLE: begin
                    start = pend;
                end
                GPT_FW_BLK: begin
                    if (s_reg.fw_rate != GPT_R1X) begin
                        s_next.ad_stb = ~s_reg.ad_stb;
                    end
                    if (s_reg.fw_rate == GPT_R4X) begin
                        s_next.ad_stb_n = s_reg.ad_stb;
                        s_next.sb_stb_n = ~s_reg.sb_stb_n;
                    end
                    if (s_reg.fcnt == `GPT_BLOCK_LAST) begin
                        s_next.fw_valid = 1'b0;
                        s_next.ad_stb = '0;
                        s_next.ad_stb_n = '0;
                        s_next.sb_stb_n = 1'b0;
                        if (s_reg.fw_rate == GPT_R1X) begin
                            s_next.fst = GPT_FW_GAP;
                        end else begin
                            s_next.fst = GPT_FW_IDLE;
                            start = pend;
                        end
                    end else begin
                        s_next.fcnt = s_reg.fcnt + 2'h1;
                    end
                end
                GPT_FW_GAP: begin
                    s_next.fst = GPT_FW_IDLE;
                end
                default: begin
                    s_next.fst = GPT_FW_IDLE;
                end
            endcase
            // Early ack lets the core load the next word during a block
            if (start) begin
                s_next.fwt_seen = s_reg.fwt_s2;
                s_next.ack_tgl = ~s_reg.ack_tgl;
                s_next.fst = GPT_FW_BLK;
                s_next.fcnt = 2'h0;
                s_next.fw_valid = 1'b1;
                s_next.fw_data = c_reg.data;
                s_next.fw_rate = fw_mode;
            end
        end
    end

    always_ff @(posedge lk.link_clk or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign lk.req_ready = s_reg.req_ready;
    assign lk.rsp_valid = s_reg.rsp_valid;
    assign lk.rsp_data = s_reg.rsp_data;
    assign lk.fw_valid = s_reg.fw_valid;
    assign lk.fw_data = s_reg.fw_data;
    assign lk.fw_rate = s_reg.fw_rate;
    assign lk.ad_stb = s_reg.ad_stb;
    assign lk.ad_stb_n = s_reg.ad_stb_n;
    assign lk.sb_stb_n = s_reg.sb_stb_n;
    assign rate_cap_out = s_reg.rate_cap;
    assign rate_mode_out = s_reg.mode;
    assign rate_locked_out = s_reg.rate_lock;
    assign mem_valid_out = s_reg.mem_valid;
    assign mem_write_out = s_reg.mem_write;
    assign mem_hi_pri_out = s_reg.mem_hi;
    assign mem_snoop_out = s_reg.mem_snoop;
    assign mem_be_out = s_reg.mem_be;
    assign mem_addr_out = s_reg.mem_addr;
    assign mem_wdata_out = s_reg.mem_wdata;
    assign fence_active_out = s_reg.fence;

    // ----------------------------------------
    // Core side: fast-write request handshake
    // ----------------------------------------
    always_comb begin
        c_next = c_reg;
        c_next.ack_s1 = s_reg.ack_tgl;
        c_next.ack_s2 = c_reg.ack_s1;
        if (fw_req_in && !c_reg.busy) begin
            c_next.data = fw_data_in;
            c_next.fw_tgl = ~c_reg.fw_tgl;
        end
        c_next.busy = c_next.fw_tgl != c_reg.ack_s2;
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            c_reg <= '0;
        end else if (clk_en_in) begin
            c_reg <= c_next;
        end
    end

    assign fw_busy_out = c_reg.busy;
endmodule

// ### tb/gpt_link_asserts.sv
// Checker on the port link between the hub end and the graphics end.
// Assumes link signals change only on rising link_clk edges.
`timescale 1ns/10ps
`include "gpt_defines.svh"
module gpt_link_asserts (
    input wire logic link_clk,
    input wire logic arst_n_in,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [3:0] req_cmd,
    input wire logic req_frame,
    input wire logic rsp_valid,
    input wire logic [63:0] rsp_data,
    input wire logic fw_valid,
    input wire logic [31:0] fw_data,
    input wire gpt_pkg::gpt_rate_t fw_rate,
    input wire logic [1:0] ad_stb,
    input wire logic [1:0] ad_stb_n,
    input wire logic sb_stb_n
);
    import gpt_pkg::*;
    logic [1:0] beat_reg;
    logic take;
    // Beat counter wraps, so back-to-back blocks restart at zero
    assign take = req_valid && req_ready && !req_frame;
    always_ff @(posedge link_clk or negedge arst_n_in) begin
        if (!arst_n_in) begin
            beat_reg <= 2'h0;
        end else begin
            beat_reg <= fw_valid ? beat_reg + 2'h1 : 2'h0;
        end
    end
    default clocking link_cb @(posedge link_clk);
    endclocking
    default disable iff (!arst_n_in);
    AST_FW_BEATS: assert property ($rose(fw_valid) |-> fw_valid [*4])
        else $error("block too short");
    AST_FW_HOLD: assert property (
        fw_valid && beat_reg != 2'h0 |-> $stable(fw_data) && $stable(fw_rate))
        else $error("block word changed");
    AST_GAP_1X: assert property (
        fw_valid && fw_rate == GPT_R1X && beat_reg == 2'h3 |=> !fw_valid)
        else $error("no idle after 1x block");
    AST_STB_TOGGLE: assert property (
        fw_valid && fw_rate != GPT_R1X && beat_reg != 2'h0 |-> ad_stb == ~$past(ad_stb))
        else $error("strobe did not toggle");
    AST_STB_4X: assert property (
        fw_valid && fw_rate == GPT_R4X && beat_reg != 2'h0
        |-> ad_stb_n == $past(ad_stb) && sb_stb_n != $past(sb_stb_n))
        else $error("4x complement strobes wrong");
    AST_STB_IDLE: assert property (
        !fw_valid || fw_rate == GPT_R1X |-> ad_stb == 2'h0 && ad_stb_n == 2'h0 && !sb_stb_n)
        else $error("strobe active outside 2x/4x block");
    AST_FLUSH: assert property (
        take && req_cmd == 4'hA |=> rsp_valid && rsp_data == `GPT_FILL_QW)
        else $error("flush answer wrong");
    AST_SILENT: assert property (
        take && req_cmd inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, [4'hB:4'hF]}
        |=> !rsp_valid [*3])
        else $error("answer to silent command");
endmodule

// ### tb/graphics_port_target_fastwrite_bench.sv
// Bench: hub end and graphics end joined by the link; user sides driven here.
// Assumes the rtl files and gpt_link_asserts are compiled first.
`timescale 1ns/10ps
`include "gpt_defines.svh"
module graphics_port_target_fastwrite_bench;
    import gpt_pkg::*;
    typedef struct packed {
        logic [31:0] a;
        logic [63:0] w;
        logic wr;
        logic hi;
        logic snp;
        logic [7:0] be;
    } gpt_note_t;
    logic clk = 1'b0, lclk = 1'b0, arst_n = 1'b0, fw_req = 1'b0, c_valid = 1'b0;
    logic c_frame = 1'b0, m_ready = 1'b0, m_rvalid = 1'b0, m_wack = 1'b0;
    logic fw_busy, m_valid, m_write, m_hi, m_snoop, locked, c_busy, r_valid;
    logic [7:0] pcr = 8'h00;
    logic [7:0] m_be;
    logic [3:0] c_cmd = 4'h0;
    logic [31:0] fw_dat = 32'h0, c_addr = 32'h0, m_addr;
    logic [63:0] m_rdata = 64'h0, c_wdata = 64'h0, m_wdata, r_data, d;
    logic [2:0] rate_cap;
    logic [15:0] fw_bytes;
    gpt_rate_t rate_mode;
    gpt_note_t note, seen, mq[$];
    logic [63:0] dq[$];
    bit kq[$];
    bit fenced = 1'b0;
    int err_count = 0, tests_run = 0, pend = 0, n;
    logic [7:0] pcrs [4] = '{8'h11, 8'h12, 8'h04, 8'h14};
    gpt_rate_t modes [4] = '{GPT_R1X, GPT_R2X, GPT_R1X, GPT_R4X};
    logic [15:0] per [4] = '{16'h0004, 16'h0008, 16'h0004, 16'h0010};
    always #5 clk = ~clk;
    always #40 lclk = ~lclk;
    gpt_link_if lk (.link_clk(lclk));
    gpt_dev_end gpt_dev_end_i (.core_clk_in(clk), .arst_n_in(arst_n), .clk_en_in(1'b1), .lk(lk),
        .port_command_register_in(pcr), .rate_cap_out(rate_cap), .rate_mode_out(rate_mode),
        .rate_locked_out(locked), .fw_req_in(fw_req), .fw_data_in(fw_dat), .fw_busy_out(fw_busy),
        .mem_valid_out(m_valid), .mem_write_out(m_write), .mem_hi_pri_out(m_hi),
        .mem_snoop_out(m_snoop), .mem_be_out(m_be), .mem_addr_out(m_addr),
        .mem_wdata_out(m_wdata), .mem_ready_in(m_ready), .mem_rvalid_in(m_rvalid),
        .mem_rdata_in(m_rdata), .mem_wack_in(m_wack), .fence_active_out());
    gpt_gfx_end gpt_gfx_end_i (.core_clk_in(clk), .arst_n_in(arst_n), .clk_en_in(1'b1), .lk(lk),
        .cmd_valid_in(c_valid), .cmd_in(c_cmd), .addr_in(c_addr), .wdata_in(c_wdata),
        .frame_in(c_frame), .cmd_busy_out(c_busy), .rsp_valid_out(r_valid),
        .rsp_data_out(r_data), .fw_bytes_out(fw_bytes));
    gpt_link_asserts gpt_link_asserts_i (.link_clk(lclk), .arst_n_in(arst_n),
        .req_valid(lk.req_valid), .req_ready(lk.req_ready), .req_cmd(lk.req_cmd),
        .req_frame(lk.req_frame), .rsp_valid(lk.rsp_valid), .rsp_data(lk.rsp_data),
        .fw_valid(lk.fw_valid), .fw_data(lk.fw_data), .fw_rate(lk.fw_rate),
        .ad_stb(lk.ad_stb), .ad_stb_n(lk.ad_stb_n), .sb_stb_n(lk.sb_stb_n));
    task automatic cmp(input string nm, input logic [127:0] e, input logic [127:0] g);
        tests_run++;
        if (e !== g) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic results;
        if (err_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wait_free(input bit fw);
        int k;
        k = 0;
        @(posedge clk);
        while ((fw ? fw_busy : c_busy) !== 1'b0 && k < 400) begin
            @(posedge clk);
            k++;
        end
        if (k == 400) begin
            err_count++;
            results();
        end
    endtask
    // -----------------------------------------------------------
    // Memory side: random stalls, late write acks, read data
    // -----------------------------------------------------------
    always @(posedge lclk) begin
        m_rvalid <= 1'b0;
        m_wack <= 1'b0;
        m_ready <= 1'($urandom_range(1));
        // Writes after a fence may still be open at a later read
        if (lk.req_valid && lk.req_ready && lk.req_cmd inside {4, 5, 7, 12, 15})
            fenced = !lk.req_frame && lk.req_cmd == 4'hC;
        if (m_valid && m_ready) begin
            note = mq.pop_front();
            seen = {m_addr, m_write ? m_wdata : 64'h0, m_write, m_hi, m_snoop, m_write ? m_be : 8'h0};
            cmp("memory access", 128'(note), 128'(seen));
            if (m_write) begin
                pend++;
            end else begin
                cmp("read passed fence", 128'h0, 128'(fenced && pend > 0));
                d = {$urandom, $urandom};
                dq.push_back(d);
                m_rdata <= d;
                m_rvalid <= 1'b1;
            end
        end
        if (pend > 0 && $urandom_range(1) == 1) begin
            m_wack <= 1'b1;
            pend--;
        end
    end
    always @(posedge clk) begin
        if (r_valid === 1'b1 && kq.size() == 0)
            cmp("unexpected answer", 128'h0, 128'h1);
        else if (r_valid === 1'b1 && kq.pop_front())
            cmp("fill answer", 128'(`GPT_FILL_QW), 128'(r_data));
        else if (r_valid === 1'b1)
            cmp("read answer", 128'(dq.pop_front()), 128'(r_data));
    end
    task automatic send(input logic [3:0] c, input bit hub, input bit fr);
        logic [31:0] a;
        logic [63:0] w;
        bit rd, wr;
        a = (hub ? `GPT_HUB_BASE : 32'h0) | ($urandom & 32'h0FFF_FFF8);
        w = {$urandom, $urandom};
        rd = fr ? c inside {4'h6, 4'hC, 4'hE} : c inside {4'h0, 4'h1, 4'h8, 4'h9};
        wr = fr ? c inside {4'h7, 4'hF} : c inside {4'h4, 4'h5};
        if (!fr && (c == 4'hA || rd && hub)) kq.push_back(1'b1);
        if (rd && !hub) kq.push_back(1'b0);
        if (rd && !hub || wr && !(hub && fr))
            mq.push_back('{a, wr ? w : 64'h0, wr, !fr && c[0], fr, (wr && !hub) ? 8'hFF : 8'h0});
        wait_free(1'b0);
        c_cmd <= c;
        c_addr <= a;
        c_wdata <= w;
        c_frame <= fr;
        c_valid <= 1'b1;
        @(posedge clk);
        c_valid <= 1'b0;
    endtask
    initial begin
        void'($urandom(32'hB7B01A00));
        for (int i = 0; i < 4; i++) begin
            @(posedge lclk);
            arst_n <= 1'b0;
            pcr <= pcrs[i];
            repeat (3) @(posedge lclk);
            arst_n <= 1'b1;
            repeat (6) @(posedge lclk);
            @(posedge clk);
            cmp("rate capability", 128'(3'h7), 128'(rate_cap));
            if (pcrs[i][4]) cmp("rate mode", 128'(modes[i]), 128'(rate_mode));
            repeat (3) begin
                wait_free(1'b1);
                fw_dat <= $urandom;
                fw_req <= 1'b1;
                @(posedge clk);
                fw_req <= 1'b0;
            end
            for (n = 0; n < 400 && fw_bytes !== 16'(12 * per[i]); n++) @(posedge clk);
            cmp("fast-write bytes", 128'(16'(12 * per[i])), 128'(fw_bytes));
            if (n == 400) results();
        end
        pcr <= 8'h12;
        foreach (pcrs[i]) send(i < 2 ? 4'h4 : i == 2 ? 4'hC : 4'h0, 1'b0, 1'b0);
        for (int i = 0; i < 64; i++) begin
            send(i[3:0], i[5], i[4]);
        end
        repeat (40) send(4'($urandom), 1'($urandom), 1'($urandom));
        for (n = 0; n < 4000 && kq.size() + mq.size() > 0; n++) @(posedge clk);
        cmp("notes left", 128'h0, 128'(kq.size() + mq.size()));
        cmp("locked rate", 128'({GPT_R4X, 1'b1}), 128'({rate_mode, locked}));
        results();
    end
endmodule
